// [rtl/brownout_map.svh]
`ifndef BROWNOUT_MAP_SVH
`define BROWNOUT_MAP_SVH

// byte addresses of the register words
`define OFS_POWER_CTRL   8'h00
`define OFS_IRQ_ENABLE   8'h04
`define OFS_RESET_SOURCE 8'h08
`define OFS_IRQ_STATUS   8'h0c
`define OFS_IRQ_MASK     8'h10
`define OFS_STATE        8'h14

// power control register fields
`define PMODE_MSB   1
`define PMODE_LSB   0
`define BOSEL_BIT   4
`define BO_OFF_BIT  5
`define PWR_WMASK   8'h33
`define PWR_RST     8'h00

// irq enable register fields
`define BO_IE_BIT   5
`define GLB_IE_BIT  7
`define IEN_WMASK   8'ha0
`define IEN_RST     8'h00

// reset source register fields
`define PO_FLG_BIT  4
`define BO_FLG_BIT  5

// interrupt status and mask layout
`define ST_BOIRQ    0
`define ST_BOEVT    1
`define ST_POEVT    2
`define ST_W        3
`define ST_RST      3'h0
`define MASK_RST    3'h1

// state register fields
`define SR_CFG      0
`define SR_ACTIVE   1
`define SR_BOLVL    2
`define SR_POLVL    3
`define SR_MODE_LSB 4

// bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// [rtl/brownout_pkg.sv]
package brownout_pkg;

  // power reduction modes, encoding as held in the field
  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'h0,
    MODE_IDLE      = 2'h1,
    MODE_POWERDOWN = 2'h2,
    MODE_TOTAL_PD  = 2'h3
  } power_mode_t;

  typedef enum logic {
    WR_IDLE = 1'b0,
    WR_RESP = 1'b1
  } wr_state_t;

  typedef enum logic {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_t;

  // synchronised comparator levels
  typedef struct packed {
    logic poweron;
    logic brownout;
  } mon_t;

  // captured write request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       strb;
  } wr_req_t;

endpackage : brownout_pkg

// [rtl/level_sync.sv]
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // two flops per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_reg;
      logic hold_reg;
      always_ff @(posedge clk_sys) begin
        if (reset) begin
          meta_reg <= 1'b0;
          hold_reg <= 1'b0;
        end else begin
          meta_reg <= async_in[i];
          hold_reg <= meta_reg;
        end
      end
      // one writer per bit keeps the output vector single-driven
      assign sync_out[i] = hold_reg;
    end
  endgenerate

endmodule : level_sync

// [rtl/brownout_poweron_control.sv]
`timescale 1ns/1ps
`include "brownout_map.svh"
module brownout_poweron_control (
  input  wire logic                      clk_sys,
  input  wire logic                      reset,
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  input  wire logic                      brownout_config_enable,
  input  wire logic                      brownout_detect_raw,
  input  wire logic                      poweron_detect_raw,
  output logic                           brownout_reset_req,
  output logic                           brownout_detect_active,
  output brownout_pkg::power_mode_t      power_mode,
  output logic                           mode_idle,
  output logic                           mode_powerdown,
  output logic                           mode_total_powerdown,
  output logic                           irq
);

  // register state
  logic [7:0]             power_control_register;
  logic [7:0]             irq_enable_register;
  logic                   brownout_flag;
  logic                   poweron_flag;
  logic [`ST_W-1:0]       status_reg;
  logic [`ST_W-1:0]       mask_reg;
  logic                   cfg_reg;
  logic                   cfg_loaded_reg;
  logic                   bo_prev_reg;
  logic                   po_prev_reg;
  brownout_pkg::mon_t     mon;

  // bus state
  brownout_pkg::wr_state_t wr_state_reg;
  brownout_pkg::wr_state_t wr_state_next;
  brownout_pkg::rd_state_t rd_state_reg;
  brownout_pkg::wr_req_t   req_reg;
  logic                    aw_held_reg;
  logic                    w_held_reg;

  // comparator levels cross into clk_sys before any use
  level_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({poweron_detect_raw, brownout_detect_raw}),
    .sync_out (mon)
  );

  // the strap is static, so one capture after reset is enough
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg_reg        <= 1'b0;
      cfg_loaded_reg <= 1'b0;
    end else if (!cfg_loaded_reg) begin
      cfg_reg        <= brownout_config_enable;
      cfg_loaded_reg <= 1'b1;
    end
  end

  // field views
  brownout_pkg::power_mode_t mode_field;
  wire bo_select   = power_control_register[`BOSEL_BIT];
  wire bo_pd       = power_control_register[`BO_OFF_BIT];
  wire bo_irq_en   = irq_enable_register[`BO_IE_BIT];
  wire glb_irq_en  = irq_enable_register[`GLB_IE_BIT];
  assign mode_field =
    brownout_pkg::power_mode_t'(power_control_register[`PMODE_MSB:`PMODE_LSB]);

  // detection gating: strap, mode and power-down bit
  wire not_total   = (mode_field != brownout_pkg::MODE_TOTAL_PD);
  wire detect_on   = cfg_reg && not_total && !bo_pd;

  // events on rising synchronised levels; the reset request follows the brownout level
  wire bo_event    = detect_on && mon.brownout && !bo_prev_reg;
  wire po_event    = mon.poweron && !po_prev_reg;
  wire bo_reset    = detect_on && mon.brownout && !bo_select;
  wire bo_irq_evt  = bo_event && bo_select && bo_irq_en && glb_irq_en;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bo_prev_reg <= 1'b0;
      po_prev_reg <= 1'b0;
    end else begin
      bo_prev_reg <= mon.brownout;
      po_prev_reg <= mon.poweron;
    end
  end

  // write channel: address and data may arrive in either order
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire wr_fire  = (wr_state_reg == brownout_pkg::WR_IDLE) && aw_held_reg && w_held_reg;
  wire b_done   = s_axi_bvalid && s_axi_bready;
  wire aw_hnext = (aw_held_reg || aw_take) && !b_done;
  wire w_hnext  = (w_held_reg || w_take) && !b_done;

  always_comb begin
    wr_state_next = wr_state_reg;
    unique case (wr_state_reg)
      brownout_pkg::WR_IDLE: begin
        if (wr_fire) begin
          wr_state_next = brownout_pkg::WR_RESP;
        end
      end
      brownout_pkg::WR_RESP: begin
        if (b_done) begin
          wr_state_next = brownout_pkg::WR_IDLE;
        end
      end
    endcase
  end

  // write address decode
  wire sel_pwr    = (req_reg.addr == `OFS_POWER_CTRL);
  wire sel_ien    = (req_reg.addr == `OFS_IRQ_ENABLE);
  wire sel_rsrc   = (req_reg.addr == `OFS_RESET_SOURCE);
  wire sel_stat   = (req_reg.addr == `OFS_IRQ_STATUS);
  wire sel_mask   = (req_reg.addr == `OFS_IRQ_MASK);
  wire sel_state  = (req_reg.addr == `OFS_STATE);
  wire wr_hit     = sel_pwr || sel_ien || sel_rsrc || sel_stat || sel_mask || sel_state;
  wire wr_lane    = wr_fire && req_reg.strb;
  wire we_pwr     = wr_lane && sel_pwr;
  wire we_ien     = wr_lane && sel_ien;
  wire we_rsrc    = wr_lane && sel_rsrc;
  wire we_stat    = wr_lane && sel_stat;
  wire we_mask    = wr_lane && sel_mask;

  // software clears a flag by writing 0 to its bit
  wire bo_flag_clear = we_rsrc && !req_reg.data[`BO_FLG_BIT];
  wire po_flag_clear = we_rsrc && !req_reg.data[`PO_FLG_BIT];
  wire bo_flag_set   = bo_event || (po_event && cfg_reg);

  // event vector for the sticky status word
  logic [`ST_W-1:0] st_set;
  assign st_set[`ST_BOIRQ] = bo_irq_evt;
  assign st_set[`ST_BOEVT] = bo_event;
  assign st_set[`ST_POEVT] = po_event;
  wire [`ST_W-1:0] st_clr  = we_stat ? req_reg.data[`ST_W-1:0] : `ST_RST;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_state_reg  <= brownout_pkg::WR_IDLE;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      req_reg       <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      wr_state_reg  <= wr_state_next;
      aw_held_reg   <= aw_hnext;
      w_held_reg    <= w_hnext;
      if (aw_take) begin
        req_reg.addr <= s_axi_awaddr;
      end
      if (w_take) begin
        req_reg.data <= s_axi_wdata[7:0];
        req_reg.strb <= s_axi_wstrb[0];
      end
      // readies drop once a beat is held, so nothing is taken twice
      s_axi_awready <= !aw_hnext && (wr_state_next == brownout_pkg::WR_IDLE);
      s_axi_wready  <= !w_hnext && (wr_state_next == brownout_pkg::WR_IDLE);
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers; power-down bit comes up 0
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      power_control_register <= `PWR_RST;
      irq_enable_register    <= `IEN_RST;
      mask_reg               <= `MASK_RST;
    end else begin
      if (we_pwr) begin
        power_control_register <= req_reg.data & `PWR_WMASK;
      end
      if (we_ien) begin
        irq_enable_register <= req_reg.data & `IEN_WMASK;
      end
      if (we_mask) begin
        mask_reg <= req_reg.data[`ST_W-1:0];
      end
    end
  end

  // sticky flags: a set in the same cycle as a clear wins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      brownout_flag <= 1'b0;
      poweron_flag  <= 1'b0;
      status_reg    <= `ST_RST;
    end else begin
      brownout_flag <= bo_flag_set || (brownout_flag && !bo_flag_clear);
      poweron_flag  <= po_event || (poweron_flag && !po_flag_clear);
      status_reg    <= st_set | (status_reg & ~st_clr);
    end
  end

  // registered outputs toward the system
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      brownout_reset_req     <= 1'b0;
      brownout_detect_active <= 1'b0;
      power_mode             <= brownout_pkg::MODE_NORMAL;
      mode_idle              <= 1'b0;
      mode_powerdown         <= 1'b0;
      mode_total_powerdown   <= 1'b0;
      irq                    <= 1'b0;
    end else begin
      brownout_reset_req     <= bo_reset;
      brownout_detect_active <= detect_on;
      power_mode             <= mode_field;
      mode_idle              <= (mode_field == brownout_pkg::MODE_IDLE);
      mode_powerdown         <= (mode_field == brownout_pkg::MODE_POWERDOWN);
      mode_total_powerdown   <= (mode_field == brownout_pkg::MODE_TOTAL_PD);
      irq                    <= |(status_reg & mask_reg);
    end
  end

  // read side: one outstanding read, data registered with the answer
  wire ar_take = s_axi_arvalid && s_axi_arready;
  wire r_done  = s_axi_rvalid && s_axi_rready;

  logic [7:0] rsrc_view;
  logic [7:0] state_view;
  always_comb begin
    rsrc_view = 8'h00;
    rsrc_view[`BO_FLG_BIT] = brownout_flag;
    rsrc_view[`PO_FLG_BIT] = poweron_flag;
    state_view = 8'h00;
    state_view[`SR_CFG]    = cfg_reg;
    state_view[`SR_ACTIVE] = detect_on;
    state_view[`SR_BOLVL]  = mon.brownout;
    state_view[`SR_POLVL]  = mon.poweron;
    state_view[`SR_MODE_LSB+1:`SR_MODE_LSB] = mode_field;
  end

  // read address decode
  wire rd_pwr   = (s_axi_araddr == `OFS_POWER_CTRL);
  wire rd_ien   = (s_axi_araddr == `OFS_IRQ_ENABLE);
  wire rd_rsrc  = (s_axi_araddr == `OFS_RESET_SOURCE);
  wire rd_stat  = (s_axi_araddr == `OFS_IRQ_STATUS);
  wire rd_mask  = (s_axi_araddr == `OFS_IRQ_MASK);
  wire rd_state = (s_axi_araddr == `OFS_STATE);
  wire rd_hit   = rd_pwr || rd_ien || rd_rsrc || rd_stat || rd_mask || rd_state;
  wire [7:0] rd_byte =
    ({8{rd_pwr}}   & power_control_register) |
    ({8{rd_ien}}   & irq_enable_register) |
    ({8{rd_rsrc}}  & rsrc_view) |
    ({8{rd_stat}}  & {5'h00, status_reg}) |
    ({8{rd_mask}}  & {5'h00, mask_reg}) |
    ({8{rd_state}} & state_view);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_state_reg  <= brownout_pkg::RD_IDLE;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      unique case (rd_state_reg)
        brownout_pkg::RD_IDLE: begin
          s_axi_arready <= !ar_take;
          if (ar_take) begin
            rd_state_reg <= brownout_pkg::RD_DATA;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        brownout_pkg::RD_DATA: begin
          if (r_done) begin
            rd_state_reg  <= brownout_pkg::RD_IDLE;
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
          end
        end
      endcase
    end
  end

  // checks on the monitor behaviour
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  cfg_off_a: assert property (!cfg_reg |=> !brownout_detect_active)
    else $error("detection active with strap unprogrammed");

  total_pd_a: assert property (!not_total |=> !brownout_reset_req)
    else $error("brownout reset in total power down");

  pd_bit_off_a: assert property (bo_pd |=> !brownout_detect_active && !brownout_reset_req)
    else $error("detection active with power-down bit set");

  bo_reset_a: assert property (detect_on && mon.brownout && !bo_select
    |=> brownout_reset_req && brownout_flag)
    else $error("brownout did not request reset");

  bo_irq_a: assert property (bo_irq_evt && mask_reg[`ST_BOIRQ] && !we_mask && !we_stat
    |=> status_reg[`ST_BOIRQ] ##1 irq)
    else $error("brownout interrupt not raised");

  no_irq_a: assert property (bo_event && bo_select && !(bo_irq_en && glb_irq_en)
    && !status_reg[`ST_BOIRQ]
    |=> !status_reg[`ST_BOIRQ] && !brownout_reset_req)
    else $error("suppressed brownout gave reset or interrupt");

  bo_flag_set_a: assert property (bo_event |=> brownout_flag)
    else $error("brownout flag not set");

  bo_flag_hold_a: assert property (brownout_flag && !bo_flag_clear |=> brownout_flag)
    else $error("brownout flag lost without clear");

  po_flag_set_a: assert property (po_event |=> poweron_flag)
    else $error("power-on flag not set");

  po_flag_only_a: assert property ($changed(poweron_flag)
    |-> $past(po_event) || $past(po_flag_clear))
    else $error("power-on flag changed without cause");

  cfg_flag_a: assert property (po_event && cfg_reg |=> brownout_flag && poweron_flag)
    else $error("brownout flag not set with power-on");

  mode_dec_a: assert property (##1 mode_total_powerdown
    == ($past(power_control_register[`PMODE_MSB:`PMODE_LSB]) == 2'h3))
    else $error("mode decode mismatch");

endmodule : brownout_poweron_control

// [verification/supply_monitor_model.sv]
`timescale 1ns/1ps
// analog comparators seen as digital levels
module supply_monitor_model (
  input  wire logic supply_low,
  input  wire logic supply_ramp,
  output logic      brownout_detect_raw,
  output logic      poweron_detect_raw
);
  // odd delays keep the levels unrelated to the clock edge; reset covers the start
  assign #13 brownout_detect_raw = supply_low;
  assign #17 poweron_detect_raw  = supply_ramp;
endmodule : supply_monitor_model

// [verification/brownout_poweron_control_tb_top.sv]
`timescale 1ns/1ps
module brownout_poweron_control_tb_top;
  logic        clk_sys, reset, brownout_config_enable, supply_low, supply_ramp;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, brownout_detect_raw, poweron_detect_raw;
  logic        brownout_reset_req, brownout_detect_active, irq;
  logic        mode_idle, mode_powerdown, mode_total_powerdown;
  brownout_pkg::power_mode_t power_mode;
  int          n_mismatch;
  int          comparisons;
  logic [1:0]  r;
  logic [31:0] d;

  // brownout cases: control, irq enable, mask, expected {reset_req, irq, flag}
  localparam logic [7:0] t_ctrl [8] = '{8'h00, 8'h10, 8'h10, 8'h10, 8'h20, 8'h13, 8'h01, 8'h10};
  localparam logic [7:0] t_ien [8] = '{8'h00, 8'ha0, 8'h20, 8'h80, 8'ha0, 8'ha0, 8'h00, 8'ha0};
  localparam logic [7:0] t_msk [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [2:0] t_exp [8] = '{3'h5, 3'h3, 3'h1, 3'h1, 3'h0, 3'h0, 3'h5, 3'h1};

  brownout_poweron_control dut (
    .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .brownout_config_enable,
    .brownout_detect_raw, .poweron_detect_raw, .brownout_reset_req,
    .brownout_detect_active, .power_mode, .mode_idle, .mode_powerdown,
    .mode_total_powerdown, .irq
  );

  supply_monitor_model supply (
    .supply_low, .supply_ramp, .brownout_detect_raw, .poweron_detect_raw
  );

  always #20 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    bit done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= wd;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    bit done;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : axi_rd

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [1:0] rs;
    axi_wr(a, wd, rs);
    chk("bresp", 32'h0, {30'h0, rs});
  endtask : wr

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic [1:0]  rs;
    axi_rd(a, rd, rs);
    chk("rresp", 32'h0, {30'h0, rs});
    chk(what, exp, rd);
  endtask : rd_chk

  // two edges through the synchronisers, one more for the flags
  task automatic pulse_poweron();
    supply_ramp <= 1'b1;
    repeat (6) @(posedge clk_sys);
    supply_ramp <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : pulse_poweron

  task automatic do_reset();
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
  endtask : do_reset

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // whole run needs well under 3000 cycles
  initial begin
    #400us;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    clk_sys = 1'b0;
    reset = 1'b1;
    brownout_config_enable = 1'b1;
    supply_low = 1'b0;
    supply_ramp = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    n_mismatch = 0;
    comparisons = 0;
    do_reset();

    // reset values, read-only state word, unmapped place
    rd_chk("power_ctrl", 8'h00, 32'h0);
    rd_chk("irq_enable", 8'h04, 32'h0);
    rd_chk("reset_source", 8'h08, 32'h0);
    rd_chk("irq_status", 8'h0c, 32'h0);
    rd_chk("irq_mask", 8'h10, 32'h1);
    wr(8'h14, 32'hff);
    rd_chk("state", 8'h14, 32'h3);
    axi_wr(8'h18, 32'h1, r);
    chk("bresp_unmapped", 32'h2, {30'h0, r});
    axi_rd(8'h18, d, r);
    chk("rresp_unmapped", 32'h2, {30'h0, r});
    chk("rdata_unmapped", 32'h0, d);
    $display("test reset_and_bus done");

    // power-on sets both flags; each clears only by a written zero
    pulse_poweron();
    rd_chk("reset_source", 8'h08, 32'h30);
    rd_chk("irq_status", 8'h0c, 32'h4);
    wr(8'h0c, 32'h4);
    rd_chk("irq_status", 8'h0c, 32'h0);
    wr(8'h08, 32'h20);
    rd_chk("reset_source", 8'h08, 32'h20);
    wr(8'h08, 32'h0);
    rd_chk("reset_source", 8'h08, 32'h0);
    $display("test poweron done");

    for (int m = 0; m < 4; m++) begin
      wr(8'h00, 32'(m));
      repeat (2) @(posedge clk_sys);
      chk("power_mode", 32'(m), {30'h0, power_mode});
      chk("mode_onehot", (m == 0) ? 32'h0 : 32'h1 << (m - 1),
          {29'h0, mode_total_powerdown, mode_powerdown, mode_idle});
      chk("detect_active", {31'h0, m != 3}, {31'h0, brownout_detect_active});
    end
    $display("test mode_decode done");

    // a stale status or flag from one case shows up in the next
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, {24'h0, t_ctrl[i]});
      wr(8'h04, {24'h0, t_ien[i]});
      wr(8'h10, {24'h0, t_msk[i]});
      supply_low <= 1'b1;
      repeat (6) @(posedge clk_sys);
      chk("reset_req", {31'h0, t_exp[i][2]}, {31'h0, brownout_reset_req});
      chk("irq", {31'h0, t_exp[i][1]}, {31'h0, irq});
      supply_low <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd_chk("reset_source", 8'h08, {26'h0, t_exp[i][0], 5'h0});
      wr(8'h08, 32'h0);
      wr(8'h0c, 32'h7);
    end
    $display("test brownout_table done");

    // unprogrammed strap: detection stays off, power-on sets one flag
    brownout_config_enable <= 1'b0;
    do_reset();
    pulse_poweron();
    rd_chk("reset_source", 8'h08, 32'h10);
    supply_low <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("reset_req", 32'h0, {31'h0, brownout_reset_req});
    chk("detect_active", 32'h0, {31'h0, brownout_detect_active});
    supply_low <= 1'b0;
    rd_chk("reset_source", 8'h08, 32'h10);
    $display("test strap_off done");
    end_of_test();
  end
endmodule : brownout_poweron_control_tb_top
